// [common/touch_adc_defs.svh]
// Purpose: Offsets, fields, reset values and timing figures of the touch converter control registers.
// Assumes: 40 MHz register clock.
// Notes:   Registers sit at byte address four times their index.
`ifndef TOUCH_ADC_DEFS_SVH
`define TOUCH_ADC_DEFS_SVH
// ======================================================================
// Register indices and values
`define BUF_IDX       6'h02
`define REF_IDX       6'h03
`define SOFT_IDX      6'h04
`define CFG_IDX       6'h05
`define BUF_RST       16'h0200
`define REF_RST       16'h0002
`define SOFT_RST      16'hFFFF
`define CFG_RST       16'h0000
`define BUF_WMASK     16'hF800
`define REF_WMASK     16'h003F
`define CFG_WMASK     16'h007F
`define SOFT_CODE     16'hBB00
// ======================================================================
// Field positions
`define BUF_EN_BIT    15
`define BUF_MODE_BIT  14
`define BUF_TL_HI     13
`define BUF_TL_LO     11
`define BUF_FULL_BIT  10
`define BUF_EMPTY_BIT 9
`define REF_SRC_BIT   4
`define REF_DLY_HI    3
`define REF_DLY_LO    2
`define REF_PWDN_BIT  1
`define REF_LVL_BIT   0
`define CFG_PEN_BIT   6
`define CFG_PRE_HI    5
`define CFG_PRE_LO    3
`define CFG_SNS_HI    2
`define CFG_SNS_LO    0
`define BUF_DEPTH     64
// ======================================================================
// Timing in microseconds and the conversion to cycles
`define CLK_MHZ       40
`define US2CYC(t)     ((t) * `CLK_MHZ)
`define SETTLE_T1_US  100
`define SETTLE_T2_US  500
`define SETTLE_T3_US  1000
`define PRE_T0_US     20
`define PRE_T1_US     84
`define PRE_T2_US     276
`define PRE_T3_US     340
`define PRE_T4_US     1044
`define PRE_T5_US     1108
`define PRE_T7_US     1364
`define SNS_T0_US     32
`define SNS_T1_US     96
`define SNS_T2_US     544
`define SNS_T3_US     608
`define SNS_T4_US     2080
`define SNS_T5_US     2144
`define SNS_T6_US     2592
`define SNS_T7_US     2656
`endif

// [common/touch_adc_pkg.sv]
// Purpose: Types shared by the touch converter control logic.
// Assumes: Nothing beyond the defs header.
// Notes:   Reference states follow a Gray path.
package touch_adc_pkg;
  // ======================================================================
  // Reference sequencing
  typedef enum logic [1:0] {
    REF_OFF    = 2'b00,
    REF_SETTLE = 2'b01,
    REF_READY  = 2'b11
  } ref_state_t;
endpackage

// [core/buffer_tracker.sv]
// Purpose: Pointer, fill and flag tracking for the converted-result buffer.
// Assumes: Write and read strobes come from logic on pclk.
// Notes:   Writes into a full buffer and reads of an empty one are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_defs.svh"
module buffer_tracker #(
  parameter int DEPTH = `BUF_DEPTH
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       single_shot,
  input  wire logic [2:0] level_code,
  input  wire logic       result_wr,
  input  wire logic       result_rd,
  output logic      [5:0] rd_ptr,
  output logic      [5:0] wr_ptr,
  output logic      [5:0] trig_ptr,
  output logic            full,
  output logic            empty,
  output logic            trig_hit,
  output logic            conv_en
);
  if (DEPTH != 64) begin : g_chk
    $error("buffer_tracker serves a depth of 64 only");
  end
  logic [5:0] rd_ff, wr_ff, tg_ff;
  logic [6:0] cnt_ff;
  logic       full_ff, empty_ff, hit_ff, conv_ff;
  wire        do_wr   = result_wr && !full_ff;
  wire        do_rd   = result_rd && !empty_ff;
  wire  [6:0] nxt_cnt = cnt_ff + {6'h00, do_wr} - {6'h00, do_rd};
  wire  [6:0] lvl_m1  = {1'b0, level_code, 3'b111};
  wire        nxt_hit = nxt_cnt > lvl_m1;
  wire  [5:0] nxt_rd  = rd_ff + {5'h00, do_rd};
  // ======================================================================
  // Pointers and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ff <= '0; wr_ff <= '0; tg_ff <= '0; cnt_ff <= '0;
      full_ff <= 1'b0; empty_ff <= 1'b1; hit_ff <= 1'b0; conv_ff <= 1'b0;
    end else if (!enable) begin
      rd_ff <= '0; wr_ff <= '0; tg_ff <= '0; cnt_ff <= '0;
      full_ff <= 1'b0; empty_ff <= 1'b1; hit_ff <= 1'b0; conv_ff <= 1'b0;
    end else begin
      rd_ff    <= nxt_rd;
      wr_ff    <= wr_ff + {5'h00, do_wr};
      tg_ff    <= nxt_rd + lvl_m1[5:0];
      cnt_ff   <= nxt_cnt;
      full_ff  <= (nxt_cnt == 7'h40);
      empty_ff <= (nxt_cnt == 7'h00);
      hit_ff   <= nxt_hit;
      conv_ff  <= !(single_shot && nxt_hit);
    end
  end
  assign rd_ptr = rd_ff; assign wr_ptr = wr_ff; assign trig_ptr = tg_ff;
  assign full = full_ff; assign empty = empty_ff;
  assign trig_hit = hit_ff; assign conv_en = conv_ff;
  // ======================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_full_count;
    full_ff |-> cnt_ff == 7'h40 && !empty_ff;
  endproperty
  a_full_count: assert property (p_full_count) else $error("full flag without 64 entries");
  property p_empty_count;
    enable && $past(enable) |-> empty_ff == (cnt_ff == 7'h00);
  endproperty
  a_empty_count: assert property (p_empty_count) else $error("empty flag disagrees with fill");
  property p_single_stop;
    enable && single_shot && nxt_hit |=> !conv_ff;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single shot kept converting");
  property p_trig_level;
    enable && $past(enable) |-> hit_ff == (cnt_ff >= ({4'h0, $past(level_code)} + 7'h01) * 7'h08);
  endproperty
  a_trig_level: assert property (p_trig_level) else $error("trigger level wrong");
endmodule // buffer_tracker
`default_nettype wire

// [core/delay_timer.sv]
// Purpose: One-shot down counter that raises done a set number of cycles after start.
// Assumes: start is a single-cycle pulse on pclk.
// Notes:   A load of zero finishes at once; done holds until the next start.
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int CNT_W = 17
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  done
);
  if (CNT_W < 1) begin : g_chk
    $error("delay_timer needs a counter of one bit at least");
  end
  logic [CNT_W-1:0] cnt_ff;
  logic             busy_ff;
  logic             done_ff;
  wire              last = busy_ff && (cnt_ff <= CNT_W'(1));
  // ======================================================================
  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start) begin
      cnt_ff  <= load;
      busy_ff <= (load != '0);
      done_ff <= (load == '0);
    end else if (busy_ff) begin
      cnt_ff  <= cnt_ff - CNT_W'(1);
      busy_ff <= !last;
      done_ff <= last;
    end
  end
  assign done = done_ff;
endmodule // delay_timer
`default_nettype wire

// [core/touch_adc_regs.sv]
// Purpose: APB register set controlling buffer, reference and touch timing of the converter.
// Assumes: Engine strobes are on pclk; APB master follows the standard protocol.
// Notes:   Zero wait state; unmapped addresses read zero and raise pslverr.
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_defs.svh"
// Functional notes
// - Buffer enable low clears all pointers
// - Mode bit: continuous or single shot
// - Trigger level is eight times code+1
// - Full flag set at 64 unread
// - Empty flag when nothing unread, resets 1
// - Source bit: external 0, internal 1
// - Settle delay 0/100/500/1000 us
// - Delay only internal and power-down mode
// - Power-down bit: on always or between
// - External source keeps internal reference off
// - Level bit selects 1.25 or 2.50 V
// - Magic code restores all control defaults
// - Pen detect disable bit, resets 0
// - Precharge time chosen by three-bit code
// - Sense time chosen by three-bit code
module touch_adc_regs
  import touch_adc_pkg::*;
#(
  parameter int PADDR_W   = 8,
  parameter int CNT_W     = 17,
  parameter int SETTLE_C2 = `US2CYC(`SETTLE_T2_US),
  parameter int SETTLE_C3 = `US2CYC(`SETTLE_T3_US),
  parameter int PRE_C2    = `US2CYC(`PRE_T2_US),
  parameter int PRE_C3    = `US2CYC(`PRE_T3_US),
  parameter int PRE_C4    = `US2CYC(`PRE_T4_US),
  parameter int PRE_C5    = `US2CYC(`PRE_T5_US),
  parameter int PRE_C7    = `US2CYC(`PRE_T7_US),
  parameter int SNS_C2    = `US2CYC(`SNS_T2_US),
  parameter int SNS_C3    = `US2CYC(`SNS_T3_US),
  parameter int SNS_C4    = `US2CYC(`SNS_T4_US),
  parameter int SNS_C5    = `US2CYC(`SNS_T5_US),
  parameter int SNS_C6    = `US2CYC(`SNS_T6_US),
  parameter int SNS_C7    = `US2CYC(`SNS_T7_US)
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               result_wr,
  input  wire logic               result_rd,
  input  wire logic               conv_req,
  input  wire logic               precharge_start,
  input  wire logic               sense_start,
  output logic      [5:0]         buffer_read_pointer,
  output logic      [5:0]         buffer_write_pointer,
  output logic      [5:0]         buffer_trigger_pointer,
  output logic                    buffer_trigger_hit,
  output logic                    conv_enable,
  output logic                    ref_power_on,
  output logic                    ref_internal,
  output logic                    ref_level_high,
  output logic                    measure_go,
  output logic                    pen_detect_en,
  output logic                    precharge_done,
  output logic                    sense_done
);
  localparam int SETTLE_C1 = `US2CYC(`SETTLE_T1_US);
  localparam int PRE_C0    = `US2CYC(`PRE_T0_US);
  localparam int PRE_C1    = `US2CYC(`PRE_T1_US);
  localparam int SNS_C0    = `US2CYC(`SNS_T0_US);
  localparam int SNS_C1    = `US2CYC(`SNS_T1_US);

  if (PADDR_W < 8 || SNS_C7 >= (1 << CNT_W) || PRE_C7 >= (1 << CNT_W)) begin : g_chk
    $error("touch_adc_regs: address or counter width too small");
  end

  // ======================================================================
  // Selection helper shared by the precharge and sense times
  function automatic logic [CNT_W-1:0] pick8(input logic [2:0] code,
      input int c0, input int c1, input int c2, input int c3,
      input int c4, input int c5, input int c6, input int c7);
    int v;
    v = 0;
    case (code)
      3'h0:    v = c0;
      3'h1:    v = c1;
      3'h2:    v = c2;
      3'h3:    v = c3;
      3'h4:    v = c4;
      3'h5:    v = c5;
      3'h6:    v = c6;
      default: v = c7;
    endcase
    return CNT_W'(v);
  endfunction

  // ======================================================================
  // APB decode
  logic [15:0] buf_ctrl_ff;
  logic [15:0] ref_ctrl_ff;
  logic [15:0] soft_ff;
  logic [15:0] cfg_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  wire  [5:0]  word_idx = paddr[7:2];
  wire         sel_buf  = (word_idx == `BUF_IDX);
  wire         sel_ref  = (word_idx == `REF_IDX);
  wire         sel_soft = (word_idx == `SOFT_IDX);
  wire         sel_cfg  = (word_idx == `CFG_IDX);
  wire         hi_zero  = (paddr[PADDR_W-1:2] == (PADDR_W-2)'(word_idx)) && (paddr[1:0] == 2'b00);
  wire         mapped   = hi_zero && (sel_buf || sel_ref || sel_soft || sel_cfg);
  wire         setup    = psel && !penable;
  wire         wr_go    = psel && penable && pready_ff && pwrite && mapped;
  wire  [15:0] wdat     = pwdata[15:0];
  wire         soft_hit = wr_go && sel_soft && (wdat == `SOFT_CODE);

  // ======================================================================
  // Buffer state seen through the register
  logic        buf_full;
  logic        buf_empty;
  wire  [15:0] buf_view = {buf_ctrl_ff[15:11], buf_full, buf_empty, 9'h000};
  wire  [15:0] rd_mux   = !mapped ? 16'h0000 :
                          sel_buf ? buf_view :
                          sel_ref ? (ref_ctrl_ff & `REF_WMASK) :
                          sel_soft ? soft_ff :
                          (cfg_ff & `CFG_WMASK);

  // ======================================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ctrl_ff <= `BUF_RST;
      ref_ctrl_ff <= `REF_RST;
      soft_ff     <= `SOFT_RST;
      cfg_ff      <= `CFG_RST;
    end else if (soft_hit) begin
      buf_ctrl_ff <= `BUF_RST;
      ref_ctrl_ff <= `REF_RST;
      soft_ff     <= `SOFT_RST;
      cfg_ff      <= `CFG_RST;
    end else if (wr_go) begin
      if (sel_buf)  buf_ctrl_ff <= wdat & `BUF_WMASK;
      if (sel_ref)  ref_ctrl_ff <= wdat & `REF_WMASK;
      if (sel_soft) soft_ff     <= wdat;
      if (sel_cfg)  cfg_ff      <= wdat & `CFG_WMASK;
    end
  end

  // Zero wait: the answer is prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= (setup && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ======================================================================
  // Field views
  wire       buf_en     = buf_ctrl_ff[`BUF_EN_BIT];
  wire       buf_single = buf_ctrl_ff[`BUF_MODE_BIT];
  wire [2:0] buf_tl     = buf_ctrl_ff[`BUF_TL_HI:`BUF_TL_LO];
  wire       ref_src    = ref_ctrl_ff[`REF_SRC_BIT];
  wire [1:0] ref_dly    = ref_ctrl_ff[`REF_DLY_HI:`REF_DLY_LO];
  wire       ref_pwdn   = ref_ctrl_ff[`REF_PWDN_BIT];
  wire       ref_lvl    = ref_ctrl_ff[`REF_LVL_BIT];
  wire [2:0] pre_code   = cfg_ff[`CFG_PRE_HI:`CFG_PRE_LO];
  wire [2:0] sns_code   = cfg_ff[`CFG_SNS_HI:`CFG_SNS_LO];

  // ======================================================================
  // Buffer tracking
  buffer_tracker #(
    .DEPTH (`BUF_DEPTH)
  ) u_buf (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (buf_en),
    .single_shot (buf_single),
    .level_code  (buf_tl),
    .result_wr   (result_wr),
    .result_rd   (result_rd),
    .rd_ptr      (buffer_read_pointer),
    .wr_ptr      (buffer_write_pointer),
    .trig_ptr    (buffer_trigger_pointer),
    .full        (buf_full),
    .empty       (buf_empty),
    .trig_hit    (buffer_trigger_hit),
    .conv_en     (conv_enable)
  );

  // ======================================================================
  // Reference sequencing
  // Without the internal source the internal reference never powers up.
  wire             ref_needs = ref_src && (!ref_pwdn || conv_req);
  wire             dly_apply = ref_src && ref_pwdn && (ref_dly != 2'b00);
  wire [CNT_W-1:0] settle_cyc = (ref_dly == 2'b01) ? CNT_W'(SETTLE_C1) :
                                (ref_dly == 2'b10) ? CNT_W'(SETTLE_C2) :
                                (ref_dly == 2'b11) ? CNT_W'(SETTLE_C3) : '0;
  ref_state_t      ref_state_ff;
  ref_state_t      nxt_ref_state;
  logic            settle_done;
  logic            ref_on_ff;
  logic            ref_int_ff;
  logic            ref_lvl_ff;
  logic            go_ff;
  logic            pen_en_ff;
  wire             settle_start = (ref_state_ff == REF_OFF) && ref_needs && dly_apply;

  always_comb begin
    nxt_ref_state = ref_state_ff;
    case (ref_state_ff)
      REF_OFF:    if (ref_needs) nxt_ref_state = dly_apply ? REF_SETTLE : REF_READY;
      REF_SETTLE: if (!ref_needs) nxt_ref_state = REF_OFF;
                  else if (settle_done) nxt_ref_state = REF_READY;
      REF_READY:  if (!ref_needs) nxt_ref_state = REF_OFF;
      default:    nxt_ref_state = REF_OFF;
    endcase
  end

  delay_timer #(
    .CNT_W (CNT_W)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (settle_start),
    .load    (settle_cyc),
    .done    (settle_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_state_ff <= REF_OFF;
      ref_on_ff    <= 1'b0;
      ref_int_ff   <= 1'b0;
      ref_lvl_ff   <= 1'b0;
      go_ff        <= 1'b0;
      pen_en_ff    <= 1'b0;
    end else begin
      ref_state_ff <= nxt_ref_state;
      ref_on_ff    <= ref_needs;
      ref_int_ff   <= ref_src;
      ref_lvl_ff   <= ref_lvl;
      go_ff        <= conv_req && (!ref_src || nxt_ref_state == REF_READY);
      pen_en_ff    <= !cfg_ff[`CFG_PEN_BIT];
    end
  end
  assign ref_power_on   = ref_on_ff;
  assign ref_internal   = ref_int_ff;
  assign ref_level_high = ref_lvl_ff;
  assign measure_go     = go_ff;
  assign pen_detect_en  = pen_en_ff;

  // ======================================================================
  // Touch timing
  // The unlisted precharge code reuses the longest time rather than guessing a new one.
  wire [CNT_W-1:0] pre_cyc = pick8(pre_code, PRE_C0, PRE_C1, PRE_C2, PRE_C3,
                                   PRE_C4, PRE_C5, PRE_C7, PRE_C7);
  wire [CNT_W-1:0] sns_cyc = pick8(sns_code, SNS_C0, SNS_C1, SNS_C2, SNS_C3,
                                   SNS_C4, SNS_C5, SNS_C6, SNS_C7);

  delay_timer #(
    .CNT_W (CNT_W)
  ) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (precharge_start),
    .load    (pre_cyc),
    .done    (precharge_done)
  );

  delay_timer #(
    .CNT_W (CNT_W)
  ) u_sns (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (sense_start),
    .load    (sns_cyc),
    .done    (sense_done)
  );

  // ======================================================================
  // Checks
  logic [CNT_W:0]   settle_age_ff;
  logic [CNT_W-1:0] settle_load_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_age_ff  <= '0;
      settle_load_ff <= '0;
    end else if (settle_start) begin
      settle_age_ff  <= '0;
      settle_load_ff <= settle_cyc;
    end else if (ref_state_ff == REF_SETTLE) begin
      settle_age_ff  <= settle_age_ff + (CNT_W+1)'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_soft_write;
    wr_go && sel_soft && wdat == `SOFT_CODE;
  endsequence
  sequence s_defaults;
    buf_ctrl_ff == `BUF_RST && ref_ctrl_ff == `REF_RST && cfg_ff == `CFG_RST && soft_ff == `SOFT_RST;
  endsequence
  property p_soft_reset;
    s_soft_write |=> s_defaults;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register changed");

  property p_ext_off;
    !ref_src |=> !ref_on_ff;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("internal reference on with external source");

  property p_settle_cond;
    $rose(ref_state_ff == REF_SETTLE) |-> $past(ref_src) && $past(ref_pwdn);
  endproperty
  a_settle_cond: assert property (p_settle_cond) else $error("settle delay without power-down mode");

  property p_settle_len;
    ref_state_ff == REF_READY && $past(ref_state_ff) == REF_SETTLE
      |-> settle_age_ff == {1'b0, settle_load_ff} + (CNT_W+1)'(1);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle delay length wrong");

  property p_buf_clear;
    !buf_en |=> buffer_read_pointer == 6'h00 && buffer_write_pointer == 6'h00
                && buffer_trigger_pointer == 6'h00 && buf_empty;
  endproperty
  a_buf_clear: assert property (p_buf_clear) else $error("pointers not cleared when disabled");

  property p_resv_zero;
    setup && !pwrite && sel_buf && mapped |=> prdata_ff[8:0] == 9'h000 && prdata_ff[31:16] == 16'h0000;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits read nonzero");

  property p_full_read;
    setup && !pwrite && sel_buf && mapped |=> prdata_ff[`BUF_FULL_BIT] == $past(buf_full)
                                            && prdata_ff[`BUF_EMPTY_BIT] == $past(buf_empty);
  endproperty
  a_full_read: assert property (p_full_read) else $error("flag readback wrong");

  property p_pen;
    cfg_ff[`CFG_PEN_BIT] |=> !pen_en_ff;
  endproperty
  a_pen: assert property (p_pen) else $error("pen detect still enabled");
endmodule // touch_adc_regs
`default_nettype wire

// [test/apb_host.sv]
// Purpose: APB host model that issues single register transfers.
// Assumes: The slave answers with pready; the waiting time is not fixed here.
// Notes:   Signals change only by NBA right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ======================================================================
  // Transfer
  // Callers keep bit five of reference_control at zero and send soft_reset only the restore code.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The wait has no cap of its own, so a silent slave ends in the bench watchdog.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // apb_host
`default_nettype wire

// [test/touch_adc_control_registers_tb.sv]
// Purpose: Self-checking bench for the touch converter control registers.
// Assumes: Zero wait state APB slave; short settle and timer counts.
// Notes:   Rows cover reset values, masks and the restore code.
`timescale 1ns/1ps
`default_nettype none
module touch_adc_control_registers_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        rwr, rrd, creq, pst, sst, hit, cen, ron, rint, rhi, mgo, pen, pdn, sdn;
  logic [5:0]  rdp, wrp, tgp;
  int          fail_count = 0;
  int          n_compared = 0;
  typedef struct packed { logic w; logic [7:0] a; logic [31:0] d; } row_t;
  row_t rows [16] = '{{1'b0, 8'h08, 32'h200}, {1'b0, 8'h0C, 32'h2}, {1'b0, 8'h10, 32'hFFFF},
    {1'b0, 8'h14, 32'h0}, {1'b1, 8'h08, 32'hFFFFFFFF}, {1'b0, 8'h08, 32'hFA00}, {1'b1, 8'h0C, 32'h1F},
    {1'b0, 8'h0C, 32'h1F}, {1'b1, 8'h14, 32'hFFFF}, {1'b0, 8'h14, 32'h7F}, {1'b1, 8'h10, 32'hBB00},
    {1'b0, 8'h08, 32'h200}, {1'b0, 8'h0C, 32'h2}, {1'b0, 8'h14, 32'h0}, {1'b0, 8'h10, 32'hFFFF},
    {1'b0, 8'h18, 32'h0}};
  apb_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  touch_adc_regs #(.SETTLE_C2(40), .PRE_C2(30), .SNS_C2(30), .PRE_C7(50)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .result_wr(rwr), .result_rd(rrd), .conv_req(creq),
    .precharge_start(pst), .sense_start(sst), .buffer_read_pointer(rdp), .buffer_write_pointer(wrp),
    .buffer_trigger_pointer(tgp), .buffer_trigger_hit(hit), .conv_enable(cen), .ref_power_on(ron),
    .ref_internal(rint), .ref_level_high(rhi), .measure_go(mgo), .pen_detect_en(pen),
    .precharge_done(pdn), .sense_done(sdn));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ======================================================================
  // Watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
  // ======================================================================
  // Tests
  initial begin
    {presetn, rwr, rrd, creq, pst, sst} = 6'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      host.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
      if (!rows[i].w) chk("prdata", rows[i].d, q);
      chk("pslverr", {31'h0, rows[i].a == 8'h18}, {31'h0, e});
    end
    $display("row test done");
    wr(8'h08, 32'h8000);
    @(posedge pclk) rwr <= 1'b1;
    repeat (64) @(posedge pclk);
    rwr <= 1'b0;
    rd(8'h08, 32'h8400);
    chk("hit cen full", 32'h3, {30'h0, hit, cen});
    @(posedge pclk) rrd <= 1'b1;
    @(posedge pclk) rrd <= 1'b0;
    wt(2);
    chk("trig_ptr", 32'h8, {26'h0, tgp});
    rd(8'h08, 32'h8000);
    wr(8'h08, 32'h0);
    wt(2);
    chk("ptrs", 32'h0, {14'h0, rdp, wrp, tgp});
    wr(8'h08, 32'hC800);
    @(posedge pclk) rwr <= 1'b1;
    repeat (15) @(posedge pclk);
    rwr <= 1'b0;
    wt(1);
    chk("hit cen 15", 32'h1, {30'h0, hit, cen});
    @(posedge pclk) rwr <= 1'b1;
    @(posedge pclk) rwr <= 1'b0;
    wt(1);
    chk("hit cen 16", 32'h2, {30'h0, hit, cen});
    $display("buffer test done");
    wr(8'h0C, 32'h11);
    wt(3);
    chk("ref int hi on", 32'h7, {29'h0, rint, rhi, ron});
    wr(8'h0C, 32'h1);
    wt(3);
    chk("ref int on", 32'h0, {30'h0, rint, ron});
    wr(8'h0C, 32'h1A);
    @(posedge pclk) creq <= 1'b1;
    wt(20);
    chk("measure_go early", 32'h0, {31'h0, mgo});
    wt(40);
    chk("measure_go late", 32'h1, {31'h0, mgo});
    @(posedge pclk) creq <= 1'b0;
    $display("reference test done");
    wr(8'h14, 32'h52);
    @(posedge pclk) pst <= 1'b1;
    sst <= 1'b1;
    @(posedge pclk) pst <= 1'b0;
    sst <= 1'b0;
    wt(15);
    chk("timers early", 32'h0, {30'h0, pdn, sdn});
    wt(25);
    chk("timers late pen", 32'h6, {29'h0, pdn, sdn, pen});
    wr(8'h14, 32'h30);
    @(posedge pclk) pst <= 1'b1;
    @(posedge pclk) pst <= 1'b0;
    wt(45);
    chk("pre code 6 early", 32'h1, {30'h0, pdn, pen});
    wt(10);
    chk("pre code 6 late", 32'h3, {30'h0, pdn, pen});
    $display("timer test done");
    @(posedge pclk) presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h200);
    rd(8'h0C, 32'h2);
    $display("reset test done");
    complete_run();
  end
endmodule // touch_adc_control_registers_tb
`default_nettype wire
